// ==== supply_protection_state_control.sv ====
// Command-driven protection, hold mode and machine-state control of a power supply.
`include "spc_consts.svh"
module supply_protection_state_control (
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    cmd_valid_i,
  input  wire spc_pkg::cmd_t           cmd_i,
  output logic                         cmd_ready_o,
  input  wire logic                    group_trigger_i,
  input  wire logic [`SPC_VAL_W-1:0]   meas_voltage_i,
  input  wire logic [`SPC_VAL_W-1:0]   meas_current_i,
  input  wire logic                    constant_current_operation_i,
  input  wire logic                    constant_voltage_operation_i,
  input  wire logic [`SPC_VAL_W-1:0]   overvoltage_level_i,
  input  wire logic                    overvoltage_trip_pin_i,
  input  wire logic                    remote_inhibit_input_i,
  input  wire logic [`SPC_FLT_W-1:0]   fault_cond_i,
  input  wire logic                    fault_clear_i,
  output logic [`SPC_VAL_W-1:0]        vset_o,
  output logic [`SPC_VAL_W-1:0]        iset_o,
  output spc_pkg::fold_t               fold_o,
  output logic [`SPC_FLT_W-1:0]        mask_o,
  output logic [`SPC_VAL_W-1:0]        volt_limit_o,
  output logic [`SPC_VAL_W-1:0]        curr_limit_o,
  output logic                         hold_o,
  output logic                         output_enable_o,
  output logic                         tripped_o,
  output logic                         foldback_tripped_o,
  output logic                         level_resp_valid_o,
  output logic [`SPC_VAL_W-1:0]        level_resp_o,
  output logic                         prog_error_o,
  output logic [`SPC_ERR_W-1:0]        error_code_o,
  output logic [`SPC_FLT_W-1:0]        fault_reg_o,
  output logic                         fault_indicator_output_o
);
  import spc_pkg::*;

  // Any of the three trigger sources asks for the same rank copy.
  function automatic logic is_trigger(input cmd_op_t op);
    is_trigger = (op == CMD_TRIGGER) || (op == CMD_TRIGGER_SHORT);
  endfunction : is_trigger

  localparam mach_state_t STATE_RST = '{
    vset: `SPC_VSET_RST,
    iset: `SPC_ISET_RST,
    fold: FOLD_NONE,
    mask: `SPC_MASK_RST
  };

  seq_state_t                state_r;
  mach_state_t               act_r;
  mach_state_t               buf_r;
  mach_state_t               buf_nxt;
  mach_state_t               mem_rdata;
  logic                      hold_r;
  logic                      out_on_r;
  logic                      out_en_r;
  logic                      tripped_r;
  logic                      fold_trip_r;
  logic                      fold_hit;
  logic [`SPC_VAL_W-1:0]     volt_lim_r;
  logic [`SPC_VAL_W-1:0]     curr_lim_r;
  logic                      resp_valid_r;
  logic [`SPC_VAL_W-1:0]     level_r;
  logic                      prog_err_r;
  logic [`SPC_ERR_W-1:0]     err_code_r;
  logic [`SPC_FLT_W-1:0]     fault_r;
  logic                      fault_ind_r;
  logic [1:0]                pin_raw;
  logic [1:0]                pin_s;
  logic                      take;
  logic                      trig;
  logic                      do_clear;
  logic                      exceed_hit;
  logic                      badlim_hit;
  logic                      ov_s;
  logic                      inh_s;

  // Commands are taken only while no recall is in flight.
  assign cmd_ready_o = (state_r == ST_IDLE);
  assign take        = cmd_valid_i && cmd_ready_o;
  assign do_clear    = take && (cmd_i.op == CMD_CLEAR);
  assign trig        = group_trigger_i || (take && is_trigger(cmd_i.op));

  // Pin inputs pass two flip-flops before any logic looks at them.
  assign pin_raw = {remote_inhibit_input_i, overvoltage_trip_pin_i};
  generate
    for (genvar g = 0; g < 2; g++) begin : g_sync
      logic [`SPC_SYNC_N-1:0] sync_r;
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          sync_r <= '0;
        end else begin
          sync_r <= {sync_r[0], pin_raw[g]};
        end
      end
      assign pin_s[g] = sync_r[`SPC_SYNC_N-1];
    end
  endgenerate
  assign ov_s  = pin_s[0];
  assign inh_s = pin_s[1];

  // Soft-limit checks against requested setpoints and the present operating point.
  assign exceed_hit = take && (((cmd_i.op == CMD_VOLTAGE_SET) && (cmd_i.value > volt_lim_r)) ||
                               ((cmd_i.op == CMD_CURRENT_SET) && (cmd_i.value > curr_lim_r)));
  assign badlim_hit = take &&
    (((cmd_i.op == CMD_VOLTAGE_SOFT_LIMIT) && (meas_voltage_i > cmd_i.value)) ||
     ((cmd_i.op == CMD_CURRENT_SOFT_LIMIT) && (meas_current_i > cmd_i.value)));

  // First-rank next value; a refused setpoint leaves the rank untouched.
  always_comb begin
    buf_nxt = buf_r;
    if (state_r == ST_RECALL) begin
      buf_nxt = mem_rdata;
    end else if (take && !exceed_hit) begin
      case (cmd_i.op)
        CMD_VOLTAGE_SET:              buf_nxt.vset = cmd_i.value;
        CMD_CURRENT_SET:              buf_nxt.iset = cmd_i.value;
        CMD_CURRENT_MODE_FOLDBACK_ON: buf_nxt.fold = FOLD_CURRENT;
        CMD_VOLTAGE_MODE_FOLDBACK_ON: buf_nxt.fold = FOLD_VOLTAGE;
        CMD_FOLDBACK_DISABLE:         buf_nxt.fold = FOLD_NONE;
        CMD_MASK_SET:                 buf_nxt.mask = cmd_i.value[`SPC_FLT_W-1:0];
        default:                      buf_nxt = buf_r;
      endcase
    end
  end

  // Sequencer: a recall waits one cycle for the registered slot read.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE:   state_r <= (take && (cmd_i.op == CMD_STATE_RECALL)) ? ST_RECALL : ST_IDLE;
        ST_RECALL: state_r <= ST_IDLE;
        default:   state_r <= ST_IDLE;
      endcase
    end
  end

  // First rank takes every accepted value, in hold or not; clear restores defaults.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || do_clear) begin
      buf_r <= STATE_RST;
    end else begin
      buf_r <= buf_nxt;
    end
  end

  // Active rank follows directly outside hold, otherwise only on trigger or recall.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || do_clear) begin
      act_r <= STATE_RST;
    end else if (trig || !hold_r || (state_r == ST_RECALL)) begin
      act_r <= buf_nxt;
    end
  end

  // Hold mode flag; clear leaves hold off.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || do_clear) begin
      hold_r <= 1'b0;
    end else if (take && (cmd_i.op == CMD_HOLD_ON)) begin
      hold_r <= 1'b1;
    end else if (take && (cmd_i.op == CMD_HOLD_OFF)) begin
      hold_r <= 1'b0;
    end
  end

  // Soft limits have no other writer, so they outlive any controlling program.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      volt_lim_r <= `SPC_LIM_RST;
      curr_lim_r <= `SPC_LIM_RST;
    end else if (take && !badlim_hit) begin
      if (cmd_i.op == CMD_VOLTAGE_SOFT_LIMIT) begin
        volt_lim_r <= cmd_i.value;
      end
      if (cmd_i.op == CMD_CURRENT_SOFT_LIMIT) begin
        curr_lim_r <= cmd_i.value;
      end
    end
  end

  // Programming error flag and code; the flag stays until a clear command.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || do_clear) begin
      prog_err_r <= 1'b0;
      err_code_r <= `SPC_ERR_NONE;
    end else if (exceed_hit) begin
      prog_err_r <= 1'b1;
      err_code_r <= `SPC_ERR_EXCEED;
    end else if (badlim_hit) begin
      prog_err_r <= 1'b1;
      err_code_r <= `SPC_ERR_BADLIM;
    end
  end

  // Overvoltage latch; a live trip outranks the reset command.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tripped_r <= 1'b0;
    end else if (ov_s) begin
      tripped_r <= 1'b1;
    end else if (take && (cmd_i.op == CMD_OVERVOLTAGE_RESET)) begin
      tripped_r <= 1'b0;
    end
  end

  // Foldback trips on the mode chosen in the active rank.
  assign fold_hit = ((act_r.fold == FOLD_CURRENT) && constant_current_operation_i) ||
                    ((act_r.fold == FOLD_VOLTAGE) && constant_voltage_operation_i);
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fold_trip_r <= 1'b0;
    end else if (fold_hit) begin
      fold_trip_r <= 1'b1;
    end else if (take && (cmd_i.op == CMD_OVERVOLTAGE_RESET)) begin
      fold_trip_r <= 1'b0;
    end
  end

  // Output on or off request; kept apart from the stored state.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      out_on_r <= 1'b1;
    end else if (take && (cmd_i.op == CMD_OUTPUT_OFF)) begin
      out_on_r <= 1'b0;
    end else if (take && (cmd_i.op == CMD_OUTPUT_ON)) begin
      out_on_r <= 1'b1;
    end
  end

  // The fresh fold hit and the synchronised pins act directly, saving a cycle.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      out_en_r <= 1'b0;
    end else begin
      out_en_r <= out_on_r && !tripped_r && !ov_s && !fold_trip_r && !fold_hit &&
                  !inh_s;
    end
  end

  // Overvoltage level answer, one cycle after the query.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      resp_valid_r <= 1'b0;
      level_r      <= '0;
    end else begin
      resp_valid_r <= take && (cmd_i.op == CMD_OVERVOLTAGE_LEVEL_QUERY);
      if (take && (cmd_i.op == CMD_OVERVOLTAGE_LEVEL_QUERY)) begin
        level_r <= overvoltage_level_i;
      end
    end
  end

  // Sticky fault bits; a new condition wins over a clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fault_r     <= '0;
      fault_ind_r <= 1'b0;
    end else begin
      fault_r     <= (fault_r & ~{`SPC_FLT_W{fault_clear_i}}) | fault_cond_i;
      fault_ind_r <= |(fault_r & act_r.mask);
    end
  end

  // Store snapshots the active rank as taken; the output request is not part of it.
  state_slot_mem u_slots (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .wr_en_i (take && (cmd_i.op == CMD_STATE_STORE)),
    .rd_en_i (take && (cmd_i.op == CMD_STATE_RECALL)),
    .addr_i  (cmd_i.slot),
    .wdata_i (act_r),
    .rdata_o (mem_rdata)
  );

  assign vset_o                   = act_r.vset;
  assign iset_o                   = act_r.iset;
  assign fold_o                   = act_r.fold;
  assign mask_o                   = act_r.mask;
  assign volt_limit_o             = volt_lim_r;
  assign curr_limit_o             = curr_lim_r;
  assign hold_o                   = hold_r;
  assign output_enable_o          = out_en_r;
  assign tripped_o                = tripped_r;
  assign foldback_tripped_o       = fold_trip_r;
  assign level_resp_valid_o       = resp_valid_r;
  assign level_resp_o             = level_r;
  assign prog_error_o             = prog_err_r;
  assign error_code_o             = err_code_r;
  assign fault_reg_o              = fault_r;
  assign fault_indicator_output_o = fault_ind_r;

  // Checks on the protection and state logic.
  a_level_answer: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    take && (cmd_i.op == CMD_OVERVOLTAGE_LEVEL_QUERY) |=>
      level_resp_valid_o && (level_resp_o == $past(overvoltage_level_i)))
    else $error("Overvoltage level answer missing or wrong.");

  a_trip_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    take && (cmd_i.op == CMD_OVERVOLTAGE_RESET) && !ov_s |=> !tripped_o)
    else $error("Reset command did not clear the overvoltage trip.");

  a_current_fold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (fold_o == FOLD_CURRENT) && constant_current_operation_i |=> !output_enable_o [*2])
    else $error("Current-mode foldback left the output enabled.");

  a_voltage_fold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (fold_o == FOLD_VOLTAGE) && constant_voltage_operation_i |=> foldback_tripped_o)
    else $error("Voltage-mode foldback did not trip.");

  a_foldback_disable: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    take && (cmd_i.op == CMD_FOLDBACK_DISABLE) && !hold_r |=> fold_o == FOLD_NONE)
    else $error("Foldback disable did not take effect.");

  a_limit_refuse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    badlim_hit |=> $stable(volt_limit_o) && $stable(curr_limit_o) &&
      (error_code_o == `SPC_ERR_BADLIM) && prog_error_o)
    else $error("Improper soft limit was not refused.");

  a_limit_accept: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    take && (cmd_i.op == CMD_VOLTAGE_SOFT_LIMIT) && (meas_voltage_i <= cmd_i.value) |=>
      volt_limit_o == $past(cmd_i.value))
    else $error("Valid voltage soft limit was not accepted.");

  a_setpoint_reject: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    exceed_hit |=> $stable(buf_r) && prog_error_o && (error_code_o == `SPC_ERR_EXCEED))
    else $error("Setpoint above soft limit was executed.");

  a_limit_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(take && ((cmd_i.op == CMD_VOLTAGE_SOFT_LIMIT) || (cmd_i.op == CMD_CURRENT_SOFT_LIMIT)))
      |=> $stable(volt_limit_o) && $stable(curr_limit_o))
    else $error("Soft limit changed without a limit command.");

  a_fault_pin: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (|(fault_cond_i & mask_o)) ##1 $stable(mask_o) |=> fault_indicator_output_o)
    else $error("Unmasked fault did not raise the fault indicator.");

  a_inhibit_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    inh_s |=> !output_enable_o)
    else $error("Inhibit input did not disable the output.");

  a_hold_keep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    hold_r && !trig && (state_r == ST_IDLE) && !do_clear |=> $stable(act_r))
    else $error("Active settings changed during hold mode.");

  a_trigger_copy: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    hold_r && trig && !do_clear |=> act_r == $past(buf_nxt))
    else $error("Trigger did not copy the first rank.");

  a_direct_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !hold_r && take && (cmd_i.op == CMD_VOLTAGE_SET) && !exceed_hit |=>
      vset_o == $past(cmd_i.value))
    else $error("Setpoint did not pass straight to the active rank.");

  a_recall_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_r == ST_RECALL |=> (act_r == $past(mem_rdata)) && cmd_ready_o)
    else $error("Recall did not load the stored state.");
endmodule : supply_protection_state_control

// ==== spc_consts.svh ====
// Named constants shared by the supply protection and state control design.
`ifndef SPC_CONSTS_SVH
`define SPC_CONSTS_SVH

// Widths of setpoints, fault and mask registers, slot indices and error codes; slot count and synchroniser depth.
`define SPC_VAL_W   16
`define SPC_FLT_W   8
`define SPC_SLOTS   16
`define SPC_SLOT_W  4
`define SPC_ERR_W   4
`define SPC_SYNC_N  2

// Error codes reported after a refused command.
`define SPC_ERR_NONE    4'h0
`define SPC_ERR_EXCEED  4'h6
`define SPC_ERR_BADLIM  4'h7

// Reset values of settings and soft limits.
`define SPC_VSET_RST  16'h0000
`define SPC_ISET_RST  16'h0000
`define SPC_MASK_RST  8'h00
`define SPC_LIM_RST   16'hFFFF

`endif

// ==== spc_pkg.sv ====
// Types shared by the supply protection and state control design.
package spc_pkg;
  `include "spc_consts.svh"

  // Device commands after parsing; the bus transport sits outside this block.
  typedef enum logic [4:0] {
    CMD_NOP,
    CMD_VOLTAGE_SET,
    CMD_CURRENT_SET,
    CMD_VOLTAGE_SOFT_LIMIT,
    CMD_CURRENT_SOFT_LIMIT,
    CMD_CURRENT_MODE_FOLDBACK_ON,
    CMD_VOLTAGE_MODE_FOLDBACK_ON,
    CMD_FOLDBACK_DISABLE,
    CMD_MASK_SET,
    CMD_HOLD_ON,
    CMD_HOLD_OFF,
    CMD_TRIGGER,
    CMD_TRIGGER_SHORT,
    CMD_STATE_STORE,
    CMD_STATE_RECALL,
    CMD_CLEAR,
    CMD_OUTPUT_ON,
    CMD_OUTPUT_OFF,
    CMD_OVERVOLTAGE_LEVEL_QUERY,
    CMD_OVERVOLTAGE_RESET
  } cmd_op_t;

  typedef enum logic [1:0] {
    FOLD_NONE,
    FOLD_CURRENT,
    FOLD_VOLTAGE
  } fold_t;

  typedef enum logic {
    ST_IDLE,
    ST_RECALL
  } seq_state_t;

  typedef struct packed {
    cmd_op_t                 op;
    logic [`SPC_VAL_W-1:0]   value;
    logic [`SPC_SLOT_W-1:0]  slot;
  } cmd_t;

  // One machine state: the dual-rank settings.
  typedef struct packed {
    logic [`SPC_VAL_W-1:0]  vset;
    logic [`SPC_VAL_W-1:0]  iset;
    fold_t                  fold;
    logic [`SPC_FLT_W-1:0]  mask;
  } mach_state_t;
endpackage : spc_pkg

// ==== state_slot_mem.sv ====
// Sixteen-slot store of machine states with a registered read port.
`include "spc_consts.svh"
module state_slot_mem (
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    wr_en_i,
  input  wire logic                    rd_en_i,
  input  wire logic [`SPC_SLOT_W-1:0]  addr_i,
  input  wire spc_pkg::mach_state_t    wdata_i,
  output spc_pkg::mach_state_t         rdata_o
);
  import spc_pkg::*;

  mach_state_t mem_r [`SPC_SLOTS];
  mach_state_t rdata_r;

  // Slots carry no reset, so a clear or a reset never wipes stored states.
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_r[addr_i] <= wdata_i;
    end
  end

  // Read data is registered and appears one cycle after the read enable.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_r <= '0;
    end else if (rd_en_i) begin
      rdata_r <= mem_r[addr_i];
    end
  end

  assign rdata_o = rdata_r;
endmodule : state_slot_mem

// ==== bus_controller_model.sv ====
// Bus controller model that offers parsed device commands to the block.
module bus_controller_model (
  input  wire logic     clk_i,
  input  wire logic     cmd_ready_i,
  output logic          cmd_valid_o,
  output spc_pkg::cmd_t cmd_o,
  output logic          stuck_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import spc_pkg::*;

  // Idle bus at time zero; nothing is offered before the bench asks.
  initial begin
    cmd_valid_o = 1'b0;
    cmd_o = '0;
    stuck_o = 1'b0;
  end

  // Holds one command until the edge that takes it, then releases it.
  task send(input cmd_op_t op, input logic [15:0] value, input logic [3:0] slot);
    int n;
    n = 0;
    cmd_valid_o = 1'b1;
    cmd_o = '{op: op, value: value, slot: slot};
    while (cmd_ready_i !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    // Only a port still not ready after the last try counts as stuck.
    if (cmd_ready_i !== 1'b1) begin
      stuck_o = 1'b1;
    end
    @(posedge clk_i);
    #1;
    cmd_valid_o = 1'b0;
    // A released bus shows the inverse, so a stale word is never mistaken for a command.
    cmd_o = cmd_t'(~cmd_o);
  endtask : send
endmodule : bus_controller_model

// ==== supply_protection_state_control_tb_top.sv ====
// Self-checking testbench of the supply protection and state control block.
module supply_protection_state_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import spc_pkg::*;

  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        cmd_valid, ready, gtrig = 1'b0, cc = 1'b0, cv = 1'b0, ovp = 1'b0, remote_inhibit_input = 1'b0;
  logic        fclr = 1'b0, hold, oen, trip, ftrip, lval, perr, find, stuck;
  logic [15:0] mv = 16'h0000, mi = 16'h0000, lvl = 16'h0000, vset, iset, vlim, ilim, lresp;
  logic [7:0]  fcond = 8'h00, mask, freg;
  logic [3:0]  ecode;
  cmd_t        cmd;
  fold_t       fold;
  int          err_total = 0;
  int          comparisons = 0;

  // Free-running 250 MHz clock.
  always #2 clk_i = ~clk_i;

  supply_protection_state_control u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
    .cmd_ready_o(ready), .group_trigger_i(gtrig), .meas_voltage_i(mv), .meas_current_i(mi),
    .constant_current_operation_i(cc), .constant_voltage_operation_i(cv),
    .overvoltage_level_i(lvl), .overvoltage_trip_pin_i(ovp), .remote_inhibit_input_i(remote_inhibit_input),
    .fault_cond_i(fcond), .fault_clear_i(fclr), .vset_o(vset), .iset_o(iset), .fold_o(fold),
    .mask_o(mask), .volt_limit_o(vlim), .curr_limit_o(ilim), .hold_o(hold),
    .output_enable_o(oen), .tripped_o(trip), .foldback_tripped_o(ftrip),
    .level_resp_valid_o(lval), .level_resp_o(lresp), .prog_error_o(perr),
    .error_code_o(ecode), .fault_reg_o(freg), .fault_indicator_output_o(find));

  bus_controller_model u_bus (
    .clk_i(clk_i), .cmd_ready_i(ready), .cmd_valid_o(cmd_valid), .cmd_o(cmd), .stuck_o(stuck));

  // Compares one observed value with its expectation and counts both outcomes.
  task chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step

  // One command, then one idle cycle so the strobe never toggles twice in a time step.
  task do_cmd(input cmd_op_t op, input logic [15:0] v, input logic [3:0] s);
    u_bus.send(op, v, s);
    if (stuck !== 1'b0) begin
      err_total++;
      report_and_stop();
    end
    step(1);
  endtask : do_cmd

  task report_and_stop;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence: each group drives one behaviour and checks it at the ports.
  initial begin
    repeat (12) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    step(2);
    chk("volt_limit", vlim, 16'hFFFF);
    chk("output_enable", 16'(oen), 16'h0001);
    lvl = 16'h1A2B;
    // The answer strobe stands for one cycle only, so it is looked at right after the take.
    u_bus.send(CMD_OVERVOLTAGE_LEVEL_QUERY, 16'h0000, 4'h0);
    chk("level_valid", 16'(lval), 16'h0001);
    step(1);
    chk("level_valid", 16'(lval), 16'h0000);
    chk("level", lresp, 16'h1A2B);
    // Present output above the requested limit makes the limit improper.
    mv = 16'h0100;
    mi = 16'h0010;
    do_cmd(CMD_VOLTAGE_SOFT_LIMIT, 16'h00F0, 4'h0);
    chk("volt_limit", vlim, 16'hFFFF);
    chk("error_code", 16'(ecode), 16'h0007);
    do_cmd(CMD_VOLTAGE_SOFT_LIMIT, 16'h0200, 4'h0);
    chk("volt_limit", vlim, 16'h0200);
    do_cmd(CMD_CURRENT_SOFT_LIMIT, 16'h0010, 4'h0);
    chk("curr_limit", ilim, 16'h0010);
    do_cmd(CMD_VOLTAGE_SET, 16'h0200, 4'h0);
    chk("vset", vset, 16'h0200);
    do_cmd(CMD_VOLTAGE_SET, 16'h0201, 4'h0);
    chk("vset", vset, 16'h0200);
    chk("error_code", 16'(ecode), 16'h0006);
    do_cmd(CMD_CURRENT_SET, 16'h0011, 4'h0);
    chk("iset", iset, 16'h0000);
    chk("prog_error", 16'(perr), 16'h0001);
    do_cmd(CMD_CLEAR, 16'h0000, 4'h0);
    chk("prog_error", 16'(perr), 16'h0000);
    chk("volt_limit", vlim, 16'h0200);
    // Hold mode with each of the three trigger sources in turn.
    do_cmd(CMD_HOLD_ON, 16'h0000, 4'h0);
    chk("hold", 16'(hold), 16'h0001);
    for (int k = 0; k < 3; k++) begin
      do_cmd(CMD_VOLTAGE_SET, 16'h0040 + 16'(k), 4'h0);
      do_cmd(CMD_MASK_SET, 16'h0001 + 16'(k), 4'h0);
      chk("vset", vset, (k == 0) ? 16'h0000 : 16'h003F + 16'(k));
      if (k == 0) do_cmd(CMD_TRIGGER, 16'h0000, 4'h0);
      if (k == 1) do_cmd(CMD_TRIGGER_SHORT, 16'h0000, 4'h0);
      if (k == 2) begin
        gtrig = 1'b1;
        step(1);
        gtrig = 1'b0;
        step(1);
      end
      chk("vset", vset, 16'h0040 + 16'(k));
      chk("mask", 16'(mask), 16'h0001 + 16'(k));
    end
    do_cmd(CMD_HOLD_OFF, 16'h0000, 4'h0);
    chk("hold", 16'(hold), 16'h0000);
    // Masked fault stays silent, unmasked fault reaches the indicator without commands.
    do_cmd(CMD_MASK_SET, 16'h0004, 4'h0);
    chk("mask", 16'(mask), 16'h0004);
    fcond = 8'h08;
    step(1);
    fcond = 8'h00;
    step(2);
    chk("fault_reg", 16'(freg), 16'h0008);
    chk("fault_ind", 16'(find), 16'h0000);
    fcond = 8'h04;
    step(1);
    fcond = 8'h00;
    step(2);
    chk("fault_ind", 16'(find), 16'h0001);
    fclr = 1'b1;
    step(1);
    fclr = 1'b0;
    step(2);
    chk("fault_ind", 16'(find), 16'h0000);
    // Foldback in both modes, then disabled.
    do_cmd(CMD_CURRENT_MODE_FOLDBACK_ON, 16'h0000, 4'h0);
    cv = 1'b1;
    step(2);
    chk("fold_trip", 16'(ftrip), 16'h0000);
    cc = 1'b1;
    step(2);
    chk("fold_trip", 16'(ftrip), 16'h0001);
    chk("output_enable", 16'(oen), 16'h0000);
    cc = 1'b0;
    cv = 1'b0;
    do_cmd(CMD_OVERVOLTAGE_RESET, 16'h0000, 4'h0);
    chk("fold_trip", 16'(ftrip), 16'h0000);
    do_cmd(CMD_VOLTAGE_MODE_FOLDBACK_ON, 16'h0000, 4'h0);
    cv = 1'b1;
    step(2);
    chk("fold_trip", 16'(ftrip), 16'h0001);
    cv = 1'b0;
    do_cmd(CMD_OVERVOLTAGE_RESET, 16'h0000, 4'h0);
    do_cmd(CMD_FOLDBACK_DISABLE, 16'h0000, 4'h0);
    chk("fold", 16'(fold), 16'(FOLD_NONE));
    cv = 1'b1;
    cc = 1'b1;
    step(2);
    chk("fold_trip", 16'(ftrip), 16'h0000);
    cv = 1'b0;
    cc = 1'b0;
    // Overvoltage trip holds while the pin is high, even against a reset command, and clears on a reset command once it is low.
    ovp = 1'b1;
    step(4);
    chk("tripped", 16'(trip), 16'h0001);
    chk("output_enable", 16'(oen), 16'h0000);
    do_cmd(CMD_OVERVOLTAGE_RESET, 16'h0000, 4'h0);
    chk("tripped", 16'(trip), 16'h0001);
    ovp = 1'b0;
    step(3);
    do_cmd(CMD_OVERVOLTAGE_RESET, 16'h0000, 4'h0);
    chk("tripped", 16'(trip), 16'h0000);
    step(2);
    chk("output_enable", 16'(oen), 16'h0001);
    remote_inhibit_input = 1'b1;
    step(4);
    chk("output_enable", 16'(oen), 16'h0000);
    remote_inhibit_input = 1'b0;
    step(4);
    // Snapshots taken at the moment of the store, recalled in the order they were stored.
    do_cmd(CMD_VOLTAGE_SET, 16'h0123, 4'h0);
    do_cmd(CMD_STATE_STORE, 16'h0000, 4'h3);
    do_cmd(CMD_VOLTAGE_SET, 16'h0155, 4'h0);
    do_cmd(CMD_STATE_STORE, 16'h0000, 4'hC);
    do_cmd(CMD_OUTPUT_OFF, 16'h0000, 4'h0);
    // The port refuses commands for one cycle while the slot read is in flight.
    u_bus.send(CMD_STATE_RECALL, 16'h0000, 4'h3);
    chk("cmd_ready", 16'(ready), 16'h0000);
    step(2);
    chk("vset", vset, 16'h0123);
    chk("output_enable", 16'(oen), 16'h0000);
    do_cmd(CMD_CLEAR, 16'h0000, 4'h0);
    do_cmd(CMD_STATE_RECALL, 16'h0000, 4'hC);
    step(1);
    chk("vset", vset, 16'h0155);
    // Output on is honoured again once nothing else blocks the output.
    do_cmd(CMD_OUTPUT_ON, 16'h0000, 4'h0);
    chk("output_enable", 16'(oen), 16'h0001);
    report_and_stop();
  end
endmodule : supply_protection_state_control_tb_top
